// >>> rtl/dpi_consts.vh
// Purpose: Constants for the dual pot serial command decoder
// Assumes: Included by bare name from rtl files
// Notes:   Device-type code value is arbitrary
`ifndef DPI_CONSTS_VH
`define DPI_CONSTS_VH
`define DPI_DEV_TYPE      4'hA
`define DPI_OP_RD_WIPER   4'h9
`define DPI_OP_WR_WIPER   4'hA
`define DPI_OP_RD_SLOT    4'hB
`define DPI_OP_WR_SLOT    4'hC
`define DPI_OP_SLOT2WIPER 4'hD
`define DPI_OP_WIPER2SLOT 4'hE
`define DPI_OP_GL_S2W     4'h1
`define DPI_OP_GL_W2S     4'h8
`define DPI_OP_STEP       4'h2
`define DPI_WIPER_MAX     6'h3F
`define DPI_WIPER_MIN     6'h00
`define DPI_SLOT_RESET    6'h20
`define DPI_PROG_TIME_US  5000
`define DPI_CLK_MHZ       20
`define DPI_PROG_CYCLES   (`DPI_PROG_TIME_US * `DPI_CLK_MHZ)
`endif

// >>> rtl/dpi_sync.v
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input asynchronous to clk
// Notes:   Output changes once stages two and three agree
`default_nettype none
module dpi_sync
(
    // Clock and reset
    input  wire clk,
    input  wire resetn,
    // Data
    input  wire din,
    output reg  dout
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            dout <= 1'b1;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                dout <= s3_q;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/dpi_decoder.v
// Purpose: Serial command decoder for a dual 64-tap potentiometer
// Assumes: scl and sda_in are asynchronous pins sampled by clk
// Notes:   Setting slots are flip-flops; programming time is modelled
`include "dpi_consts.vh"
`default_nettype none
// What this block does
// - Ack address only when strap bits match
// - Decode opcode, pot bit, slot bits; ack
// - Read wiper returns position, MSB first
// - Write wiper loads data byte
// - Read slot returns selected slot content
// - Write slot stores data byte
// - Global copy slot to every wiper
// - Global copy every wiper to slot
// - Copy selected wiper into its slot
// - Load selected wiper from its slot
// - Stepping mode after ack until STOP
// - Programming starts only after STOP
// - Step up on data high, down low
// - Programming busy for at most 5 ms
// - Reset loads wipers from first slot
module dpi_decoder
#(
    parameter PROG_CYCLES = `DPI_PROG_CYCLES
)
(
    // Clock and reset
    input  wire       clk,
    input  wire       resetn,
    // Serial pins
    input  wire       scl,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    // Strap address pins
    input  wire [3:0] strap_addr,
    // Wiper outputs and status
    output reg  [5:0] wiper0_q,
    output reg  [5:0] wiper1_q,
    output reg        prog_busy_q
);
    localparam S_IDLE = 6'h01;
    localparam S_ADDR = 6'h02;
    localparam S_INST = 6'h04;
    localparam S_WDAT = 6'h08;
    localparam S_RDAT = 6'h10;
    localparam S_STEP = 6'h20;

    wire scl_s;
    wire sda_s;
    reg  scl_p_q;
    reg  sda_p_q;
    reg  [5:0]  state_q;
    reg  [3:0]  bit_q;
    reg  [7:0]  sh_q;
    reg  [7:0]  tx_q;
    reg         ack_q;
    reg         acked_q;
    reg  [3:0]  op_q;
    reg         pot_q;
    reg  [1:0]  slot_q;
    reg  [5:0]  slot_mem_q [0:7];
    reg         pend_q;
    reg  [22:0] prog_cnt_q;
    reg         init_q;
    integer     i;

    wire scl_rise = scl_s & ~scl_p_q;
    wire scl_fall = ~scl_s & scl_p_q;
    wire start_c  = scl_s & sda_p_q & ~sda_s;
    wire stop_c   = scl_s & ~sda_p_q & sda_s;
    wire [7:0] byte_in = {sh_q[6:0], sda_s};
    wire [5:0] sel_wiper = pot_q ? wiper1_q : wiper0_q;
    wire [2:0] sel_idx = {pot_q, slot_q};

    // ****************************************
    // Pin synchronisers
    // ****************************************
    dpi_sync u_scl (.clk(clk), .resetn(resetn), .din(scl), .dout(scl_s));
    dpi_sync u_sda (.clk(clk), .resetn(resetn), .din(sda_in),
                    .dout(sda_s));

    // ****************************************
    // Frame decoder and wiper state
    // ****************************************
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            scl_p_q     <= 1'b1;
            sda_p_q     <= 1'b1;
            state_q     <= S_IDLE;
            bit_q       <= 4'h0;
            sh_q        <= 8'h00;
            tx_q        <= 8'h00;
            ack_q       <= 1'b0;
            acked_q     <= 1'b0;
            op_q        <= 4'h0;
            pot_q       <= 1'b0;
            slot_q      <= 2'h0;
            sda_out     <= 1'b0;
            sda_oe      <= 1'b0;
            wiper0_q    <= `DPI_WIPER_MIN;
            wiper1_q    <= `DPI_WIPER_MIN;
            prog_busy_q <= 1'b0;
            pend_q      <= 1'b0;
            prog_cnt_q  <= 23'h000000;
            init_q      <= 1'b1;
            for (i = 0; i < 8; i = i + 1)
                slot_mem_q[i] <= `DPI_SLOT_RESET;
        end
        else
        begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            // Power-up recall from first_setting_slot
            if (init_q)
            begin
                init_q   <= 1'b0;
                wiper0_q <= slot_mem_q[0];
                wiper1_q <= slot_mem_q[4];
            end
            // Programming timer
            if (prog_busy_q)
            begin
                if (prog_cnt_q == 23'h000001)
                    prog_busy_q <= 1'b0;
                prog_cnt_q <= prog_cnt_q - 23'h000001;
            end
            if (stop_c)
            begin
                state_q <= S_IDLE;
                sda_oe  <= 1'b0;
                if (pend_q)
                begin
                    pend_q      <= 1'b0;
                    prog_busy_q <= 1'b1;
                    prog_cnt_q  <= PROG_CYCLES[22:0];
                end
            end
            else if (start_c)
            begin
                state_q <= S_ADDR;
                sda_out <= 1'b0;
                bit_q   <= 4'h0;
                ack_q   <= 1'b0;
                sda_oe  <= 1'b0;
            end
            else if (state_q == S_STEP)
            begin
                // Direction taken at rise, step once the pulse ends
                // so the clock rise of STOP does not move the wiper
                if (scl_rise)
                    sh_q[0] <= sda_s;
                if (scl_fall)
                begin
                    sda_oe <= 1'b0;
                    if (sh_q[0])
                    begin
                        if (!pot_q && wiper0_q != `DPI_WIPER_MAX)
                            wiper0_q <= wiper0_q + 6'h01;
                        if (pot_q && wiper1_q != `DPI_WIPER_MAX)
                            wiper1_q <= wiper1_q + 6'h01;
                    end
                    else
                    begin
                        if (!pot_q && wiper0_q != `DPI_WIPER_MIN)
                            wiper0_q <= wiper0_q - 6'h01;
                        if (pot_q && wiper1_q != `DPI_WIPER_MIN)
                            wiper1_q <= wiper1_q - 6'h01;
                    end
                end
            end
            else if (state_q != S_IDLE)
            begin
                if (scl_rise)
                begin
                    if (ack_q)
                        acked_q <= ~sda_s;
                    else if (bit_q != 4'h8)
                    begin
                        sh_q  <= byte_in;
                        bit_q <= bit_q + 4'h1;
                    end
                end
                else if (scl_fall)
                begin
                    if (ack_q)
                    begin
                        // Ninth clock over
                        ack_q  <= 1'b0;
                        bit_q  <= 4'h0;
                        sda_oe <= 1'b0;
                        case (state_q)
                        S_ADDR:
                            state_q <= S_INST;
                        S_INST:
                        begin
                            case (op_q)
                            `DPI_OP_RD_WIPER:
                            begin
                                state_q <= S_RDAT;
                                tx_q    <= {2'b00, sel_wiper};
                                // First data bit is always zero: pull now
                                sda_out <= 1'b0;
                                sda_oe  <= 1'b1;
                            end
                            `DPI_OP_RD_SLOT:
                            begin
                                state_q <= S_RDAT;
                                tx_q <= {2'b00, slot_mem_q[sel_idx]};
                                sda_out <= 1'b0;
                                sda_oe  <= 1'b1;
                            end
                            `DPI_OP_STEP:
                                state_q <= S_STEP;
                            `DPI_OP_WR_WIPER, `DPI_OP_WR_SLOT:
                                state_q <= S_WDAT;
                            default:
                                state_q <= S_IDLE;
                            endcase
                        end
                        S_RDAT:
                            state_q <= acked_q ? S_RDAT : S_IDLE;
                        default:
                            state_q <= S_IDLE;
                        endcase
                    end
                    else if (state_q == S_RDAT)
                    begin
                        if (bit_q == 4'h8)
                        begin
                            ack_q   <= 1'b1;
                            sda_out <= 1'b0;
                        end
                        else
                            sda_out <= tx_q[3'h7 - bit_q[2:0]];
                        sda_oe <= (bit_q != 4'h8) & ~tx_q[3'h7 - bit_q[2:0]];
                    end
                    else if (bit_q == 4'h8)
                    begin
                        ack_q <= 1'b1;
                        case (state_q)
                        S_ADDR:
                            if (sh_q[7:4] == `DPI_DEV_TYPE &&
                                sh_q[3:0] == strap_addr && !prog_busy_q)
                                sda_oe <= 1'b1;
                            else
                                state_q <= S_IDLE;
                        S_INST:
                        begin
                            sda_oe <= 1'b1;
                            op_q   <= sh_q[7:4];
                            pot_q  <= sh_q[2];
                            slot_q <= sh_q[1:0];
                            case (sh_q[7:4])
                            `DPI_OP_GL_S2W:
                            begin
                                wiper0_q <= slot_mem_q[{1'b0, sh_q[1:0]}];
                                wiper1_q <= slot_mem_q[{1'b1, sh_q[1:0]}];
                            end
                            `DPI_OP_GL_W2S:
                            begin
                                slot_mem_q[{1'b0, sh_q[1:0]}] <= wiper0_q;
                                slot_mem_q[{1'b1, sh_q[1:0]}] <= wiper1_q;
                                pend_q <= 1'b1;
                            end
                            `DPI_OP_WIPER2SLOT:
                            begin
                                slot_mem_q[sh_q[2:0]] <= sh_q[2] ?
                                    wiper1_q : wiper0_q;
                                pend_q <= 1'b1;
                            end
                            `DPI_OP_SLOT2WIPER:
                            begin
                                if (sh_q[2])
                                    wiper1_q <= slot_mem_q[sh_q[2:0]];
                                else
                                    wiper0_q <= slot_mem_q[sh_q[2:0]];
                            end
                            default:
                                pot_q <= sh_q[2];
                            endcase
                        end
                        S_WDAT:
                        begin
                            sda_oe <= 1'b1;
                            if (op_q == `DPI_OP_WR_WIPER)
                            begin
                                if (pot_q)
                                    wiper1_q <= sh_q[5:0];
                                else
                                    wiper0_q <= sh_q[5:0];
                            end
                            else
                            begin
                                slot_mem_q[sel_idx] <= sh_q[5:0];
                                pend_q <= 1'b1;
                            end
                        end
                        default:
                            state_q <= S_IDLE;
                        endcase
                    end
                end
            end
            if (state_q == S_RDAT && scl_fall && ack_q)
                bit_q <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// >>> test/dpi_properties.sv
// Purpose: Port checks for the pot command decoder
// Assumes: Bound to dpi_decoder, one clock domain
// Notes:   STOP is seen on the raw pins
`default_nettype none
module dpi_properties
#(
    parameter PROG_CYCLES = 20
)
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // Serial pins
    input wire logic       scl,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    // Wipers and status
    input wire logic [5:0] wiper0_q,
    input wire logic [5:0] wiper1_q,
    input wire logic       prog_busy_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] busy_cnt_q;
    logic [7:0]  stop_age_q;
    logic        scl_q;
    logic        sda_q;
    always @(posedge clk)
    begin
        scl_q <= scl;
        sda_q <= sda_in;
        busy_cnt_q <= (resetn && prog_busy_q) ? busy_cnt_q + 32'd1 : 32'd0;
        if (!resetn || (scl && scl_q && sda_in && !sda_q))
            stop_age_q <= 8'h00;
        else if (stop_age_q != 8'hFF)
            stop_age_q <= stop_age_q + 8'h01;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_oe_pulls_low: assert property (sda_oe |-> !sda_out)
        else $error("SDA driven high");
    a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl)
        else $error("SDA enable moved while SCL high");
    a_oe_bit_hold: assert property ($rose(sda_oe) |-> sda_oe[*6])
        else $error("SDA pull too short");
    a_reload_slot0: assert property ($rose(resetn) |->
        ##[1:2] (wiper0_q == 6'h20 && wiper1_q == 6'h20))
        else $error("wipers not loaded from slot 0");
    a_busy_bound: assert property (busy_cnt_q <= PROG_CYCLES + 1)
        else $error("programming too long");
    a_busy_full: assert property ($fell(prog_busy_q) |->
        busy_cnt_q >= PROG_CYCLES - 1)
        else $error("programming too short");
    a_busy_after_stop: assert property ($rose(prog_busy_q) |->
        stop_age_q <= 8'h10)
        else $error("programming began without STOP");
    a_quiet_busy: assert property (prog_busy_q |-> !sda_oe)
        else $error("answered while programming");
    c_prog: cover property ($rose(prog_busy_q));
    c_ack: cover property ($rose(sda_oe));
    c_step: cover property ($changed(wiper1_q));
endmodule
bind dpi_decoder dpi_properties #(.PROG_CYCLES(PROG_CYCLES)) i_dpi_properties
(
    .clk(clk), .resetn(resetn), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .wiper0_q(wiper0_q),
    .wiper1_q(wiper1_q), .prog_busy_q(prog_busy_q)
);
`default_nettype wire

// >>> test/dpi_host.sv
// Purpose: Serial bus host model driving frames
// Assumes: SCL bit of 8 clk, 6 low and 2 high
// Notes:   Released SDA reads high through pull-up
`default_nettype none
module dpi_host
(
    input  wire logic clk,
    input  wire logic sda_oe,
    input  wire logic sda_out,
    output var  logic scl,
    output wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sd = 1'b1;
    initial scl = 1'b1;
    assign sda = sd & !(sda_oe & !sda_out);
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic bit_io(input logic b, output logic r);
        tick(3);
        sd = b;
        tick(3);
        scl = 1'b1;
        tick(2);
        r = sda;
        scl = 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] d, input logic a,
                           output logic [7:0] q, output logic r);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(a, r);
    endtask
    // Kind k: 2 transfer, 3 write, 4 read, 8+n stepping n bits
    task automatic frame(input logic [7:0] a, input logic [7:0] ins,
                         input logic [7:0] d, input int k,
                         output logic [7:0] q, output logic [2:0] nak);
        logic [7:0] dq;
        nak = 3'b000;
        q = 8'h00;
        tick(2);
        sd = 1'b0;
        tick(4);
        scl = 1'b0;
        byte_io(a, 1'b1, dq, nak[0]);
        byte_io(ins, 1'b1, dq, nak[1]);
        if (k == 3)
            byte_io(d, 1'b1, dq, nak[2]);
        if (k == 4)
            byte_io(8'hFF, 1'b0, q, dq[0]);
        for (int i = 8; i < k; i++)
            bit_io(d[0], dq[0]);
        tick(3);
        sd = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(4);
        sd = 1'b1;
        tick(8);
    endtask
endmodule
`default_nettype wire

// >>> test/dpi_decoder_tb_top.sv
// Purpose: Self-checking bench for dpi_decoder
// Assumes: Host model drives the serial pins
// Notes:   Programming time cut to 200 cycles
`include "dpi_consts.vh"
`default_nettype none
module dpi_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] ins;
        logic [7:0] d;
        int         k;
        logic [7:0] q;
        logic [5:0] e0;
        logic [5:0] e1;
        logic       nv;
    } dpi_row_t;
    localparam int         PC  = 200;
    localparam logic [7:0] ADR = {`DPI_DEV_TYPE, 4'h6};
    logic       clk    = 1'b0;
    logic       resetn = 1'b0;
    wire        scl;
    wire        sda;
    wire        oe;
    wire        so;
    wire  [5:0] w0;
    wire  [5:0] w1;
    wire        busy;
    logic [7:0] q;
    logic [2:0] nak;
    int         bad_count       = 0;
    int         samples_checked = 0;
    dpi_row_t   rows [12] = '{
        '{8'hA0, 8'hC5, 3, 8'h00, 6'h05, 6'h20, 1'b0},
        '{8'h90, 8'h00, 4, 8'h05, 6'h05, 6'h20, 1'b0},
        '{8'hA4, 8'h3A, 3, 8'h00, 6'h05, 6'h3A, 1'b0},
        '{8'hC6, 8'h11, 3, 8'h00, 6'h05, 6'h3A, 1'b1},
        '{8'hB6, 8'h00, 4, 8'h11, 6'h05, 6'h3A, 1'b0},
        '{8'hE3, 8'h00, 2, 8'h00, 6'h05, 6'h3A, 1'b1},
        '{8'hB3, 8'h00, 4, 8'h05, 6'h05, 6'h3A, 1'b0},
        '{8'hD6, 8'h00, 2, 8'h00, 6'h05, 6'h11, 1'b0},
        '{8'h81, 8'h00, 2, 8'h00, 6'h05, 6'h11, 1'b1},
        '{8'hB5, 8'h00, 4, 8'h11, 6'h05, 6'h11, 1'b0},
        '{8'hA0, 8'h2A, 3, 8'h00, 6'h2A, 6'h11, 1'b0},
        '{8'h11, 8'h00, 2, 8'h00, 6'h05, 6'h11, 1'b0}};
    always #25 clk = ~clk;
    dpi_host i_dpi_host (.clk(clk), .sda_oe(oe), .sda_out(so),
                         .scl(scl), .sda(sda));
    dpi_decoder #(.PROG_CYCLES(PC)) i_dpi_decoder (.clk(clk),
        .resetn(resetn), .scl(scl), .sda_in(sda), .sda_out(so),
        .sda_oe(oe), .strap_addr(4'h6), .wiper0_q(w0), .wiper1_q(w1),
        .prog_busy_q(busy));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        if (got !== exp)
            bad_count++;
    endtask
    task automatic idle();
        for (int i = 0; i < PC + 50 && busy !== 1'b0; i++)
            #50;
        chk(busy, 1'b0);
    endtask
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        #2 resetn = 1'b1;
        repeat (8) @(posedge clk);
        #2;
        chk(w0, 8'h20);
        chk(w1, 8'h20);
        $display("reset test done");
        foreach (rows[i])
        begin
            i_dpi_host.frame(ADR, rows[i].ins, rows[i].d, rows[i].k, q, nak);
            chk(nak, 3'b000);
            if (rows[i].k == 4)
                chk(q, rows[i].q);
            chk(w0, rows[i].e0);
            chk(w1, rows[i].e1);
            chk(busy, rows[i].nv);
            idle();
        end
        $display("table test done");
        i_dpi_host.frame({`DPI_DEV_TYPE, 4'h7}, 8'h90, 8'h00, 4, q, nak);
        chk(nak[0], 1'b1);
        i_dpi_host.frame(ADR, 8'hC0, 8'hFF, 3, q, nak);
        i_dpi_host.frame(ADR, 8'h90, 8'h00, 4, q, nak);
        chk(nak[0], 1'b1);
        idle();
        i_dpi_host.frame(ADR, 8'hB0, 8'h00, 4, q, nak);
        chk(q, 8'h3F);
        $display("refusal test done");
        i_dpi_host.frame(ADR, 8'hA0, 8'h3E, 3, q, nak);
        i_dpi_host.frame(ADR, 8'h20, 8'h01, 11, q, nak);
        chk(w0, 8'h3F);
        i_dpi_host.frame(ADR, 8'h20, 8'h00, 10, q, nak);
        chk(w0, 8'h3D);
        i_dpi_host.frame(ADR, 8'hA4, 8'h01, 3, q, nak);
        i_dpi_host.frame(ADR, 8'h24, 8'h00, 11, q, nak);
        chk(w1, 8'h00);
        chk(w0, 8'h3D);
        $display("step test done");
        @(posedge clk);
        #2 resetn = 1'b0;
        repeat (8) @(posedge clk);
        #2 resetn = 1'b1;
        repeat (8) @(posedge clk);
        #2;
        chk(w0, 8'h20);
        chk(w1, 8'h20);
        $display("mid reset test done");
        give_verdict();
    end
    initial
    begin
        #2000000;
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
